// ==== rtl/cidp_regs.svh ====
// Offsets, field positions, reset values and timing for the config port.
// Assumes an 8-bit internal I/O bus with 16-bit addresses.
`ifndef CIDP_REGS_SVH
`define CIDP_REGS_SVH

// Host I/O addresses of the index port, by strap level
`define CIDP_BASE_LO      16'h002e
`define CIDP_BASE_HI      16'h004e
`define CIDP_DATA_OFS     16'h0001

// Index values
`define CIDP_IDX_RST      8'h00
`define CIDP_IDX_DEVSEL   8'h07
`define CIDP_IDX_BANKED   8'h30
`define CIDP_IDX_ACT      8'h30
`define CIDP_IDX_IO0_HI   8'h60
`define CIDP_IDX_IO0_LO   8'h61
`define CIDP_IDX_IO1_HI   8'h62
`define CIDP_IDX_IO1_LO   8'h63
`define CIDP_IDX_IRQ      8'h70
`define CIDP_IDX_DMA0     8'h74
`define CIDP_IDX_DMA1     8'h75
`define CIDP_IDX_WD_TO    8'hf0
`define CIDP_IDX_WD_CFG   8'hf1
`define CIDP_IDX_WD_KICK  8'hf2

// Read values and field positions
`define CIDP_RD_ZERO      8'h00
`define CIDP_DMA_NONE     8'h04
`define CIDP_DMA_RST      3'h4
`define CIDP_ACT_BIT      0
`define CIDP_IRQ_WAKE_BIT 4
`define CIDP_WD_PP_BIT    0
`define CIDP_WD_PU_BIT    1

// Logical device numbers and bank slots
`define CIDP_NDEV         13
`define CIDP_DEV_LINEAR   8'h0a
`define CIDP_DEV_WDOG     8'h0a
`define CIDP_DEV_VOLT     8'h0d
`define CIDP_DEV_TEMP     8'h0e
`define CIDP_SLOT_WDOG    4'ha
`define CIDP_SLOT_VOLT    4'hb
`define CIDP_SLOT_TEMP    4'hc
`define CIDP_SLOT_NONE    4'hf

// Watchdog tick: 1 ms at a 50 ns clock
`define CIDP_WD_TICK_NS   1000000
`define CIDP_CLK_NS       50

`endif

// ==== rtl/cidp_pkg.sv ====
// Types shared by the config port and its watchdog.
// Assumes the constants of cidp_regs.svh.
package cidp_pkg;

  // Internal byte-wide bus request, one-cycle strobes
  typedef struct packed {
    logic [15:0] addr;
    logic        ior;
    logic        iow;
    logic [7:0]  wdata;
  } cidp_ibus_req_t;

  // Read answer
  typedef struct packed {
    logic [7:0] rdata;
    logic       rvalid;
  } cidp_ibus_rsp_t;

  // Settings of one logical device
  typedef struct packed {
    logic        active;
    logic [15:0] io_base0;
    logic [15:0] io_base1;
    logic        irq_wake;
    logic [3:0]  irq_num;
    logic [2:0]  dma_chan;
  } cidp_ldev_cfg_t;

  // Whole state of the config port
  typedef struct packed {
    logic [7:0]                index;
    logic [7:0]                dev_sel;
    logic                      base_hi;
    logic                      strap_done;
    cidp_ldev_cfg_t [12:0]     bank;
    logic [7:0]                wd_timeout;
    logic                      wd_pp;
    logic                      wd_pu;
    logic                      wd_kick;
    cidp_ibus_rsp_t            rsp;
  } cidp_state_t;

  typedef enum logic [1:0] {
    CIDP_WD_IDLE    = 2'b00,
    CIDP_WD_RUN     = 2'b01,
    CIDP_WD_EXPIRED = 2'b10
  } cidp_wd_st_t;

  // Whole state of the watchdog
  typedef struct packed {
    cidp_wd_st_t st;
    logic [15:0] pre;
    logic [7:0]  cnt;
    logic        expired;
    logic        pin_o;
    logic        pin_oe;
  } cidp_wd_state_t;

endpackage

// ==== rtl/cidp_watchdog.sv ====
// Watchdog timer and its output pin driver.
// Assumes kick is a one-cycle pulse and config is stable between writes.
`timescale 1ns/100ps
`include "cidp_regs.svh"

module cidp_watchdog #(
  parameter int TICK_CYCLES = `CIDP_WD_TICK_NS / `CIDP_CLK_NS
) (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // Configuration
  input  wire logic       enable,
  input  wire logic [7:0] timeout,
  input  wire logic       push_pull,
  input  wire logic       kick,
  // Pin
  output logic            expired,
  output logic            pin_o,
  output logic            pin_oe
);

  cidp_pkg::cidp_wd_state_t s_q, s_d;
  logic tick;
  logic fire;

  // Prescaler end and expiry moment
  assign tick = s_q.pre == 16'(TICK_CYCLES - 1);
  assign fire = (s_q.st == cidp_pkg::CIDP_WD_RUN) && tick
                && (s_q.cnt + 8'h01 == timeout);

  // Next state; an expiry in the kick cycle still wins
  always_comb begin
    s_d = s_q;
    case (s_q.st)
      cidp_pkg::CIDP_WD_IDLE: begin
        s_d.pre = 16'h0000;
        s_d.cnt = 8'h00;
        if (enable) begin
          s_d.st = cidp_pkg::CIDP_WD_RUN;
        end
      end
      cidp_pkg::CIDP_WD_RUN: begin
        s_d.pre = tick ? 16'h0000 : s_q.pre + 16'h0001;
        if (tick) begin
          s_d.cnt = s_q.cnt + 8'h01;
        end
        if (fire) begin
          s_d.st      = cidp_pkg::CIDP_WD_EXPIRED;
          s_d.expired = 1'b1;
        end else if (kick) begin
          s_d.pre = 16'h0000;
          s_d.cnt = 8'h00;
        end
      end
      cidp_pkg::CIDP_WD_EXPIRED: begin
        if (kick) begin
          s_d.st      = cidp_pkg::CIDP_WD_RUN;
          s_d.expired = 1'b0;
          s_d.pre     = 16'h0000;
          s_d.cnt     = 8'h00;
        end
      end
      default: s_d.st = cidp_pkg::CIDP_WD_IDLE;
    endcase
    if (!enable) begin
      s_d.st      = cidp_pkg::CIDP_WD_IDLE;
      s_d.expired = 1'b0;
    end
    // Open drain pulls low only; push-pull always drives
    s_d.pin_o  = push_pull ? !s_d.expired : 1'b0;
    s_d.pin_oe = push_pull | s_d.expired;
  end

  // State register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_q <= '{st: cidp_pkg::CIDP_WD_IDLE, pre: 16'h0000, cnt: 8'h00,
               expired: 1'b0, pin_o: 1'b0, pin_oe: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign expired = s_q.expired;
  assign pin_o   = s_q.pin_o;
  assign pin_oe  = s_q.pin_oe;

  sequence s_wd_fire;
    fire && enable;
  endsequence

  a_wd_expiry_low: assert property (@(posedge mclk) disable iff (rst)
    s_wd_fire |=> expired && !pin_o)
    else $error("watchdog did not drive low on expiry");
  a_wd_drive_type: assert property (@(posedge mclk) disable iff (rst)
    ##1 (pin_oe == ($past(push_pull) | expired)))
    else $error("watchdog pin enable wrong for driver type");
  a_wd_kick_clear: assert property (@(posedge mclk) disable iff (rst)
    (expired && kick && enable) |=> !expired)
    else $error("watchdog kick did not clear expiry");

endmodule

// ==== rtl/cidp_top.sv ====
// Configuration index/data port with banked logical device registers.
// Assumes single-byte internal bus cycles with one-cycle strobes.
`timescale 1ns/100ps
`include "cidp_regs.svh"

module cidp_top #(
  parameter int WD_TICK_CYCLES = `CIDP_WD_TICK_NS / `CIDP_CLK_NS
) (
  // Clock and reset
  input  wire logic                      mclk,
  input  wire logic                      rst,
  // Strap
  input  wire logic                      base_select_strap,
  // Internal bus
  input  wire cidp_pkg::cidp_ibus_req_t  ib_req,
  output cidp_pkg::cidp_ibus_rsp_t       ib_rsp,
  // Device controls
  output cidp_pkg::cidp_ldev_cfg_t [12:0] ldev_cfg,
  output logic [12:0]                    ldev_active,
  // Watchdog pin
  output logic                           watchdog_expired_out_o,
  output logic                           watchdog_expired_out_oe,
  output logic                           watchdog_pullup_en
);

  cidp_pkg::cidp_state_t s_q, s_d;
  logic [15:0] base;
  logic        hit_idx;
  logic        hit_dat;
  logic        banked;
  logic [3:0]  slot;
  logic        slot_ok;
  logic        is_wdog;
  logic [7:0]  rv;
  logic        wd_expired;

  // Bank slot of a logical device number; gaps map to none
  function automatic logic [3:0] slot_of(input logic [7:0] dnum);
    logic [3:0] s;
    s = `CIDP_SLOT_NONE;
    if (dnum <= `CIDP_DEV_LINEAR) begin
      s = dnum[3:0];
    end else if (dnum == `CIDP_DEV_VOLT) begin
      s = `CIDP_SLOT_VOLT;
    end else if (dnum == `CIDP_DEV_TEMP) begin
      s = `CIDP_SLOT_TEMP;
    end
    return s;
  endfunction

  // Address decode of the two host bytes
  assign base    = s_q.base_hi ? `CIDP_BASE_HI : `CIDP_BASE_LO;
  assign hit_idx = s_q.strap_done && (ib_req.addr == base);
  assign hit_dat = s_q.strap_done
                   && (ib_req.addr == base + `CIDP_DATA_OFS);
  assign banked  = s_q.index >= `CIDP_IDX_BANKED;
  assign slot    = slot_of(s_q.dev_sel);
  assign slot_ok = slot != `CIDP_SLOT_NONE;
  assign is_wdog = s_q.dev_sel == `CIDP_DEV_WDOG;

  // Read value of whatever the port points at
  always_comb begin
    rv = `CIDP_RD_ZERO;
    if (hit_idx) begin
      rv = s_q.index;
    end else if (!banked) begin
      if (s_q.index == `CIDP_IDX_DEVSEL) begin
        rv = s_q.dev_sel;
      end
    end else if (s_q.index == `CIDP_IDX_DMA1) begin
      rv = `CIDP_DMA_NONE;
    end else if (!slot_ok) begin
      if (s_q.index == `CIDP_IDX_DMA0) begin
        rv = `CIDP_DMA_NONE;
      end
    end else begin
      case (s_q.index)
        `CIDP_IDX_ACT:    rv = {7'h00, s_q.bank[slot].active};
        `CIDP_IDX_IO0_HI: rv = s_q.bank[slot].io_base0[15:8];
        `CIDP_IDX_IO0_LO: rv = s_q.bank[slot].io_base0[7:0];
        `CIDP_IDX_IO1_HI: rv = s_q.bank[slot].io_base1[15:8];
        `CIDP_IDX_IO1_LO: rv = s_q.bank[slot].io_base1[7:0];
        `CIDP_IDX_IRQ:    rv = {3'h0, s_q.bank[slot].irq_wake,
                                s_q.bank[slot].irq_num};
        `CIDP_IDX_DMA0:   rv = {5'h00, s_q.bank[slot].dma_chan};
        `CIDP_IDX_WD_TO:  rv = is_wdog ? s_q.wd_timeout : `CIDP_RD_ZERO;
        `CIDP_IDX_WD_CFG: rv = is_wdog ? {6'h00, s_q.wd_pu, s_q.wd_pp}
                                      : `CIDP_RD_ZERO;
        default:          rv = `CIDP_RD_ZERO;
      endcase
    end
  end

  // Next state: strap capture, index, data path, read answer
  always_comb begin
    s_d            = s_q;
    s_d.rsp.rvalid = 1'b0;
    s_d.wd_kick    = 1'b0;
    // Strap taken on the first edge after reset release
    if (!s_q.strap_done) begin
      s_d.base_hi    = base_select_strap;
      s_d.strap_done = 1'b1;
    end
    // Only byte I/O cycles reach here; DMA passes the bridge elsewhere
    if (ib_req.iow && hit_idx) begin
      s_d.index = ib_req.wdata;
    end
    // Data writes land in the indexed register, never in the port
    if (ib_req.iow && hit_dat) begin
      if (!banked) begin
        if (s_q.index == `CIDP_IDX_DEVSEL) begin
          s_d.dev_sel = ib_req.wdata;
        end
      end else if (slot_ok) begin
        case (s_q.index)
          `CIDP_IDX_ACT:
            s_d.bank[slot].active = ib_req.wdata[`CIDP_ACT_BIT];
          `CIDP_IDX_IO0_HI: s_d.bank[slot].io_base0[15:8] = ib_req.wdata;
          `CIDP_IDX_IO0_LO: s_d.bank[slot].io_base0[7:0] = ib_req.wdata;
          `CIDP_IDX_IO1_HI: s_d.bank[slot].io_base1[15:8] = ib_req.wdata;
          `CIDP_IDX_IO1_LO: s_d.bank[slot].io_base1[7:0] = ib_req.wdata;
          `CIDP_IDX_IRQ: begin
            s_d.bank[slot].irq_wake =
              ib_req.wdata[`CIDP_IRQ_WAKE_BIT];
            s_d.bank[slot].irq_num  = ib_req.wdata[3:0];
          end
          `CIDP_IDX_DMA0: s_d.bank[slot].dma_chan = ib_req.wdata[2:0];
          `CIDP_IDX_WD_TO: begin
            if (is_wdog) begin
              s_d.wd_timeout = ib_req.wdata;
            end
          end
          `CIDP_IDX_WD_CFG: begin
            if (is_wdog) begin
              s_d.wd_pp = ib_req.wdata[`CIDP_WD_PP_BIT];
              s_d.wd_pu = ib_req.wdata[`CIDP_WD_PU_BIT];
            end
          end
          `CIDP_IDX_WD_KICK: s_d.wd_kick = is_wdog;
          default: s_d.wd_kick = 1'b0;
        endcase
      end
    end
    // Read answer one cycle after the strobe, byte wide
    if (ib_req.ior && (hit_idx || hit_dat)) begin
      s_d.rsp.rdata  = rv;
      s_d.rsp.rvalid = 1'b1;
    end
  end

  // State register; every bank comes up disabled with no DMA channel
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.index <= `CIDP_IDX_RST;
      for (int i = 0; i < `CIDP_NDEV; i++) begin
        s_q.bank[i].dma_chan <= `CIDP_DMA_RST;
      end
    end else begin
      s_q <= s_d;
    end
  end

  // Per-device control signals straight from the bank registers
  for (genvar g = 0; g < `CIDP_NDEV; g++) begin : g_dev
    assign ldev_cfg[g]    = s_q.bank[g];
    assign ldev_active[g] = s_q.bank[g].active;
  end

  assign ib_rsp             = s_q.rsp;
  assign watchdog_pullup_en = s_q.wd_pu;

  cidp_watchdog #(
    .TICK_CYCLES (WD_TICK_CYCLES)
  ) u_wd (
    .mclk      (mclk),
    .rst       (rst),
    .enable    (s_q.bank[`CIDP_SLOT_WDOG].active
                && (s_q.wd_timeout != 8'h00)),
    .timeout   (s_q.wd_timeout),
    .push_pull (s_q.wd_pp),
    .kick      (s_q.wd_kick),
    .expired   (wd_expired),
    .pin_o     (watchdog_expired_out_o),
    .pin_oe    (watchdog_expired_out_oe)
  );

  sequence s_idx_write;
    ib_req.iow && hit_idx;
  endsequence

  sequence s_dat_read75;
    ib_req.ior && hit_dat && (s_q.index == `CIDP_IDX_DMA1);
  endsequence

  a_index_readback: assert property (@(posedge mclk) disable iff (rst)
    s_idx_write ##1 (ib_req.ior && hit_idx && !ib_req.iow)
    |=> ib_rsp.rvalid && ib_rsp.rdata == $past(ib_req.wdata, 2))
    else $error("index did not read back written value");
  a_strap_base: assert property (@(posedge mclk) disable iff (rst)
    $rose(s_q.strap_done) |-> s_q.base_hi == $past(base_select_strap))
    else $error("base strap not captured");
  a_dma_none_read: assert property (@(posedge mclk) disable iff (rst)
    s_dat_read75 |=> ib_rsp.rvalid && ib_rsp.rdata == `CIDP_DMA_NONE)
    else $error("index 75h did not read 04h");
  a_devsel_write: assert property (@(posedge mclk) disable iff (rst)
    (ib_req.iow && hit_dat && s_q.index == `CIDP_IDX_DEVSEL)
    |=> s_q.dev_sel == $past(ib_req.wdata))
    else $error("device number write lost");
  a_activate_bit: assert property (@(posedge mclk) disable iff (rst)
    (ib_req.iow && hit_dat && s_q.index == `CIDP_IDX_ACT && slot_ok)
    |=> ldev_active[$past(slot)] == $past(ib_req.wdata[0]))
    else $error("activate bit not applied");
  a_answer_cause: assert property (@(posedge mclk) disable iff (rst)
    ib_rsp.rvalid |-> $past(ib_req.ior && (hit_idx || hit_dat)))
    else $error("read answer without a port read");

endmodule

// ==== bench/cidp_host_model.sv ====
// Host side model: issues single-byte I/O cycles on the internal bus.
// Assumes one calling process and the strobe timing of the port contract.
`timescale 1ns/100ps

module cidp_host_model (
  // Clock
  input  wire logic                     mclk,
  // Bus
  output cidp_pkg::cidp_ibus_req_t      req,
  input  wire cidp_pkg::cidp_ibus_rsp_t rsp
);
  // Bus quiet at time zero
  initial begin
    req = '0;
  end

  // One write strobe per byte; released bus shows inverted leftovers
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    req <= '{addr: a, ior: 1'b0, iow: 1'b1, wdata: d};
    @(posedge mclk);
    req <= '{addr: ~a, ior: 1'b0, iow: 1'b0, wdata: ~d};
  endtask

  // One read strobe; answer taken in the cycle after the strobe edge
  task automatic rd(input logic [15:0] a, output logic [7:0] d,
                    output logic ok);
    @(posedge mclk);
    req <= '{addr: a, ior: 1'b1, iow: 1'b0, wdata: 8'h00};
    @(posedge mclk);
    req <= '{addr: ~a, ior: 1'b0, iow: 1'b0, wdata: 8'ha5};
    #1;
    ok = (rsp.rvalid === 1'b1);
    d  = rsp.rdata;
  endtask
endmodule

// ==== bench/config_index_data_port_tb_top.sv ====
// Self-checking bench for the config index/data port and watchdog pin.
// Assumes cidp_top, cidp_host_model and the cidp package are compiled.
`timescale 1ns/100ps

module config_index_data_port_tb_top;
  // Short watchdog tick keeps the run brief
  localparam int TICK = 8;

  logic                            mclk;
  logic                            rst;
  logic                            strap;
  cidp_pkg::cidp_ibus_req_t        req;
  cidp_pkg::cidp_ibus_rsp_t        rsp;
  cidp_pkg::cidp_ldev_cfg_t [12:0] cfg;
  logic [12:0]                     act;
  logic                            wd_o;
  logic                            wd_oe;
  logic                            wd_pu;
  logic [15:0]                     base;
  logic [7:0]                      rv;
  logic                            ok;
  int                              n_errors;
  int                              total_checks;
  logic [7:0]                      dev_nums [13] = '{8'h00, 8'h01, 8'h02,
    8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0d, 8'h0e};

  cidp_top #(.WD_TICK_CYCLES(TICK)) DUT (
    .mclk                    (mclk),
    .rst                     (rst),
    .base_select_strap       (strap),
    .ib_req                  (req),
    .ib_rsp                  (rsp),
    .ldev_cfg                (cfg),
    .ldev_active             (act),
    .watchdog_expired_out_o  (wd_o),
    .watchdog_expired_out_oe (wd_oe),
    .watchdog_pullup_en      (wd_pu)
  );

  cidp_host_model H (
    .mclk (mclk),
    .req  (req),
    .rsp  (rsp)
  );

  // 20 MHz clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // Verdict and end of run
  task automatic final_report;
    if (n_errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Compare a byte read back over the bus
  task automatic chk_rd(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask

  // Compare a level seen on the output ports
  task automatic chk_sig(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask

  // Reset with a given strap; first cycle only at the 2nd edge after
  task automatic do_reset(input logic s);
    @(posedge mclk);
    strap <= s;
    rst   <= 1'b1;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    base = s ? 16'h004e : 16'h002e;
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
    H.rd(a, rv, ok);
    chk_sig({15'h0, ok}, 16'h0001);
    chk_rd(rv, e);
  endtask

  // A read that must go unanswered
  task automatic rd_none(input logic [15:0] a);
    H.rd(a, rv, ok);
    chk_sig({15'h0, ok}, 16'h0000);
  endtask

  task automatic setreg(input logic [7:0] idx, input logic [7:0] v);
    H.wr(base, idx);
    H.wr(base + 16'h0001, v);
  endtask

  task automatic getreg(input logic [7:0] idx, input logic [7:0] e);
    H.wr(base, idx);
    rd_chk(base + 16'h0001, e);
  endtask

  // Hang guard, well past the expected run of about 730 cycles
  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    final_report();
  end

  // Main sequence
  initial begin
    n_errors     = 0;
    total_checks = 0;
    rst          = 1'b1;
    strap        = 1'b0;
    do_reset(1'b0);
    rd_chk(base, 8'h00);
    rd_none(16'h004e);
    H.wr(base, 8'h5a);
    rd_chk(base, 8'h5a);
    setreg(8'h07, 8'h03);
    getreg(8'h07, 8'h03);
    setreg(8'h20, 8'hff);
    getreg(8'h20, 8'h00);
    // Fill every bank with values unique to it
    for (int i = 0; i < 13; i++) begin
      setreg(8'h07, dev_nums[i]);
      setreg(8'h30, i[0] ? 8'hfe : 8'hff);
      setreg(8'h60, 8'(16 + i));
      setreg(8'h61, 8'(i));
      setreg(8'h70, 8'(16 + i));
      setreg(8'h74, {5'h00, 3'(i)});
    end
    // Read back bank by bank; a shared register would show the last value
    for (int i = 0; i < 13; i++) begin
      setreg(8'h07, dev_nums[i]);
      getreg(8'h30, i[0] ? 8'h00 : 8'h01);
      getreg(8'h60, 8'(16 + i));
      getreg(8'h75, 8'h04);
      getreg(8'h74, {5'h00, 3'(i)});
      chk_sig(cfg[i].io_base0, {8'(16 + i), 8'(i)});
      chk_sig({11'h0, cfg[i].irq_wake, cfg[i].irq_num}, 16'h0010 + 16'(i & 15));
    end
    chk_sig({3'h0, act}, 16'h1555);
    setreg(8'h07, 8'h0b);
    getreg(8'h30, 8'h00);
    getreg(8'h74, 8'h04);
    // Watchdog: push-pull, one tick, bank already active
    setreg(8'h07, 8'h0a);
    setreg(8'hf1, 8'h01);
    setreg(8'hf0, 8'h01);
    repeat (TICK + 6) @(posedge mclk);
    chk_sig({14'h0, wd_o, wd_oe}, 16'h0001);
    setreg(8'hf2, 8'h00);
    repeat (3) @(posedge mclk);
    chk_sig({14'h0, wd_o, wd_oe}, 16'h0003);
    // Open drain with pull-up: released until expiry, then driven low
    setreg(8'hf1, 8'h02);
    setreg(8'hf2, 8'h00);
    repeat (3) @(posedge mclk);
    chk_sig({14'h0, wd_oe, wd_pu}, 16'h0001);
    repeat (TICK + 4) @(posedge mclk);
    chk_sig({14'h0, wd_o, wd_oe}, 16'h0001);
    setreg(8'hf0, 8'h00);
    repeat (3) @(posedge mclk);
    chk_sig({15'h0, wd_oe}, 16'h0000);
    // Second reset with the strap high moves the port pair
    do_reset(1'b1);
    rd_chk(base, 8'h00);
    rd_none(16'h002e);
    setreg(8'h07, 8'h0e);
    getreg(8'h07, 8'h0e);
    final_report();
  end
endmodule
